// ==== rtl/disp_move_and_multiply_exec.sv ====
// execution logic for displacement moves, effective address, flag copy, multiplies
// assumes the fetch side holds instr_valid_i until instr_ready_o, and that
// memory answers each request with one mem_done_i pulse
`timescale 1ns/1ps
module disp_move_and_multiply_exec
   import disp_exec_pkg::*;
#(
   parameter int DATA_W = 32
) (
   input wire logic core_clk_i,
   input wire logic rst_n_i,
   input wire logic instr_valid_i,
   input wire logic [15:0] instr_i,
   input wire logic delay_slot_i,
   input wire logic [31:0] branch_dest_i,
   input wire logic test_flag_i,
   input wire logic [31:0] mem_rdata_i,
   input wire logic mem_done_i,
   output logic instr_ready_o,
   output logic [31:0] pc_o,
   output logic mem_req_o,
   output logic mem_we_o,
   output logic [1:0] mem_size_o,
   output logic [31:0] mem_addr_o,
   output logic [31:0] mem_wdata_o,
   output logic [31:0] multiply_accum_low_o,
   output logic [31:0] multiply_accum_high_o,
   output logic [31:0] fixed_data_register_o,
   output logic busy_o
);
   // datapath is fixed at one 32-bit word per register
   if (DATA_W != 32) begin : g_bad_width
      $error("DATA_W must be 32");
   end

   typedef enum logic [1:0] {ST_IDLE, ST_MEM, ST_MUL} state_type;

   state_type state_r, state_nxt;
   logic [31:0] gpr_r [16];
   logic [31:0] gpr_nxt [16];
   logic [31:0] pc_r, pc_nxt;
   logic [31:0] multiply_accum_low_r, multiply_accum_low_nxt;
   logic [31:0] multiply_accum_high_r;
   logic mem_req_r, mem_req_nxt;
   logic mem_we_r, mem_we_nxt;
   logic [1:0] size_r, size_nxt;
   logic [31:0] addr_r, addr_nxt;
   logic [31:0] wdata_r, wdata_nxt;
   logic [3:0] ldst_r, ldst_nxt;
   logic [2:0] cnt_r, cnt_nxt;
   logic [31:0] mul_res_r, mul_res_nxt;
   logic ready_r, ready_nxt;
   // busy kept in its own flop so the output is not a state decode
   logic busy_r, busy_nxt;

   wire logic [3:0] f_n = instr_i[11:8];
   wire logic [3:0] f_m = instr_i[7:4];
   wire logic [3:0] f_d = instr_i[3:0];

   // scaled zero-extended displacement plus base
   function automatic logic [31:0] disp_addr(input logic [31:0] base, input logic [3:0] d,
                                             input logic [1:0] sz);
      logic [31:0] z;
      z = {28'h000_0000, d};
      disp_addr = base + (z << sz);
   endfunction : disp_addr

   // sign extension of loaded data by size
   function automatic logic [31:0] load_ext(input logic [31:0] v, input logic [1:0] sz);
      load_ext = v;
      if (sz == SIZE_BYTE) load_ext = {{24{v[7]}}, v[7:0]};
      else if (sz == SIZE_WORD) load_ext = {{16{v[15]}}, v[15:0]};
   endfunction : load_ext

   always_comb begin
      logic [31:0] pc_base;
      logic [63:0] prod;
      pc_base = 32'h0000_0000;
      prod = 64'h0;
      state_nxt = state_r;
      pc_nxt = pc_r;
      multiply_accum_low_nxt = multiply_accum_low_r;
      mem_req_nxt = mem_req_r;
      mem_we_nxt = mem_we_r;
      size_nxt = size_r;
      addr_nxt = addr_r;
      wdata_nxt = wdata_r;
      ldst_nxt = ldst_r;
      cnt_nxt = cnt_r;
      mul_res_nxt = mul_res_r;
      ready_nxt = ready_r;
      for (int i = 0; i < 16; i++) gpr_nxt[i] = gpr_r[i];
      case (state_r)
         ST_IDLE: begin
            ready_nxt = 1'b1;
            if (instr_valid_i && ready_r) begin
               pc_nxt = delay_slot_i ? branch_dest_i : pc_r + INSTR_BYTES;
               if (instr_i[15:8] == OP_BYTE_STORE || instr_i[15:8] == OP_WORD_STORE) begin
                  size_nxt = instr_i[8] ? SIZE_WORD : SIZE_BYTE;
                  // scaled displacement
                  // short stores carry the base field in bits 7:4
                  addr_nxt = disp_addr(gpr_r[f_m], f_d, instr_i[8] ? SIZE_WORD : SIZE_BYTE);
                  wdata_nxt = gpr_r[FIXED_REG];
                  mem_we_nxt = 1'b1;
                  mem_req_nxt = 1'b1;
                  ready_nxt = 1'b0;
                  state_nxt = ST_MEM;
               end else if (instr_i[15:8] == OP_BYTE_LOAD || instr_i[15:8] == OP_WORD_LOAD) begin
                  size_nxt = instr_i[8] ? SIZE_WORD : SIZE_BYTE;
                  addr_nxt = disp_addr(gpr_r[f_m], f_d, instr_i[8] ? SIZE_WORD : SIZE_BYTE);
                  ldst_nxt = FIXED_REG;
                  mem_we_nxt = 1'b0;
                  mem_req_nxt = 1'b1;
                  ready_nxt = 1'b0;
                  state_nxt = ST_MEM;
               end else if (instr_i[15:12] == OP_LONG_STORE) begin
                  size_nxt = SIZE_LONG;
                  addr_nxt = disp_addr(gpr_r[f_n], f_d, SIZE_LONG);
                  wdata_nxt = gpr_r[f_m];
                  mem_we_nxt = 1'b1;
                  mem_req_nxt = 1'b1;
                  ready_nxt = 1'b0;
                  state_nxt = ST_MEM;
               end else if (instr_i[15:12] == OP_LONG_LOAD) begin
                  size_nxt = SIZE_LONG;
                  addr_nxt = disp_addr(gpr_r[f_m], f_d, SIZE_LONG);
                  ldst_nxt = f_n;
                  mem_we_nxt = 1'b0;
                  mem_req_nxt = 1'b1;
                  ready_nxt = 1'b0;
                  state_nxt = ST_MEM;
               end else if (instr_i[15:8] == OP_EFF_ADDR) begin
                  // pc of second instruction after, or slot target plus two
                  pc_base = delay_slot_i ? branch_dest_i + SLOT_PC_ADD
                                         : pc_r + INSTR_BYTES + INSTR_BYTES;
                  gpr_nxt[FIXED_REG] = (pc_base & PC_ALIGN_MASK)
                                     + ({24'h00_0000, instr_i[7:0]} << 2);
               end else if (instr_i[15:12] == GRP_ZERO && instr_i[7:0] == LO_COPY_FLAG) begin
                  gpr_nxt[f_n] = {31'h0000_0000, test_flag_i};
               end else if (instr_i[15:12] == GRP_ZERO && f_d == LO_LONG_MUL) begin
                  // low product bits, high mac untouched
                  prod = {32'h0, gpr_r[f_n]} * {32'h0, gpr_r[f_m]};
                  mul_res_nxt = prod[31:0];
                  cnt_nxt = LONG_MUL_CYCLES - 3'h1;
                  ready_nxt = 1'b0;
                  state_nxt = ST_MUL;
               end else if (instr_i[15:12] == GRP_TWO && f_d == LO_SMUL) begin
                  mul_res_nxt = 32'($signed(gpr_r[f_n][15:0]) * $signed(gpr_r[f_m][15:0]));
                  cnt_nxt = WORD_MUL_CYCLES - 3'h1;
                  ready_nxt = 1'b0;
                  state_nxt = ST_MUL;
               end else if (instr_i[15:12] == GRP_TWO && f_d == LO_UMUL) begin
                  mul_res_nxt = {16'h0000, gpr_r[f_n][15:0]} * {16'h0000, gpr_r[f_m][15:0]};
                  cnt_nxt = WORD_MUL_CYCLES - 3'h1;
                  ready_nxt = 1'b0;
                  state_nxt = ST_MUL;
               end
               if (state_nxt != ST_IDLE) ready_nxt = 1'b0;
            end
         end
         ST_MEM: begin
            mem_req_nxt = 1'b0;
            if (mem_done_i) begin
               if (!mem_we_r) gpr_nxt[ldst_r] = load_ext(mem_rdata_i, size_r);
               ready_nxt = 1'b1;
               state_nxt = ST_IDLE;
            end
         end
         ST_MUL: begin
            if (cnt_r == 3'h0) begin
               multiply_accum_low_nxt = mul_res_r;
               ready_nxt = 1'b1;
               state_nxt = ST_IDLE;
            end else begin
               cnt_nxt = cnt_r - 3'h1;
            end
         end
         default: state_nxt = ST_IDLE;
      endcase
      busy_nxt = (state_nxt != ST_IDLE);
   end

   always_ff @(posedge core_clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         state_r <= ST_IDLE;
         pc_r <= PC_RESET;
         multiply_accum_low_r <= 32'h0000_0000;
         multiply_accum_high_r <= 32'h0000_0000;
         mem_req_r <= 1'b0;
         mem_we_r <= 1'b0;
         size_r <= SIZE_BYTE;
         addr_r <= 32'h0000_0000;
         wdata_r <= 32'h0000_0000;
         ldst_r <= 4'h0;
         cnt_r <= 3'h0;
         mul_res_r <= 32'h0000_0000;
         ready_r <= 1'b0;
         busy_r <= 1'b0;
         for (int i = 0; i < 16; i++) gpr_r[i] <= 32'h0000_0000;
      end else begin
         state_r <= state_nxt;
         pc_r <= pc_nxt;
         multiply_accum_low_r <= multiply_accum_low_nxt;
         multiply_accum_high_r <= multiply_accum_high_r;
         mem_req_r <= mem_req_nxt;
         mem_we_r <= mem_we_nxt;
         size_r <= size_nxt;
         addr_r <= addr_nxt;
         wdata_r <= wdata_nxt;
         ldst_r <= ldst_nxt;
         cnt_r <= cnt_nxt;
         mul_res_r <= mul_res_nxt;
         ready_r <= ready_nxt;
         busy_r <= busy_nxt;
         for (int i = 0; i < 16; i++) gpr_r[i] <= gpr_nxt[i];
      end
   end

   assign instr_ready_o = ready_r;
   assign pc_o = pc_r;
   assign mem_req_o = mem_req_r;
   assign mem_we_o = mem_we_r;
   assign mem_size_o = size_r;
   assign mem_addr_o = addr_r;
   assign mem_wdata_o = wdata_r;
   assign multiply_accum_low_o = multiply_accum_low_r;
   assign multiply_accum_high_o = multiply_accum_high_r;
   assign fixed_data_register_o = gpr_r[FIXED_REG];
   assign busy_o = busy_r;

   wire logic take_w = instr_valid_i && ready_r && state_r == ST_IDLE;

   byte_store_addr_a: assert property (@(posedge core_clk_i) disable iff (!rst_n_i)
      take_w && instr_i[15:8] == OP_BYTE_STORE |=> mem_addr_o == $past(gpr_r[f_m]) + $past(f_d))
      else $error("byte store address wrong");
   word_store_addr_a: assert property (@(posedge core_clk_i) disable iff (!rst_n_i)
      take_w && instr_i[15:8] == OP_WORD_STORE
      |=> mem_addr_o == $past(gpr_r[f_m]) + {27'h0, $past(f_d), 1'b0} && mem_size_o == SIZE_WORD)
      else $error("word store address wrong");
   long_load_addr_a: assert property (@(posedge core_clk_i) disable iff (!rst_n_i)
      take_w && instr_i[15:12] == OP_LONG_LOAD
      |=> mem_addr_o == $past(gpr_r[f_m]) + {26'h0, $past(f_d), 2'b00})
      else $error("long load address wrong");
   byte_store_data_a: assert property (@(posedge core_clk_i) disable iff (!rst_n_i)
      take_w && instr_i[15:8] == OP_BYTE_STORE |=> mem_wdata_o == $past(gpr_r[FIXED_REG]))
      else $error("byte store data not fixed register");
   load_stall_a: assert property (@(posedge core_clk_i) disable iff (!rst_n_i)
      state_r == ST_MEM && !mem_done_i |=> !instr_ready_o)
      else $error("ready during pending load");
   byte_sign_ext_a: assert property (@(posedge core_clk_i) disable iff (!rst_n_i)
      state_r == ST_MEM && mem_done_i && !mem_we_r && size_r == SIZE_BYTE && ldst_r == FIXED_REG
      |=> fixed_data_register_o == {{24{$past(mem_rdata_i[7])}}, $past(mem_rdata_i[7:0])})
      else $error("byte load not sign extended");
   eff_addr_a: assert property (@(posedge core_clk_i) disable iff (!rst_n_i)
      take_w && instr_i[15:8] == OP_EFF_ADDR && !delay_slot_i
      |=> fixed_data_register_o[1:0] == 2'b00 && instr_ready_o)
      else $error("effective address misaligned or not one state");
   copy_flag_a: assert property (@(posedge core_clk_i) disable iff (!rst_n_i)
      take_w && instr_i[15:12] == GRP_ZERO && instr_i[7:0] == LO_COPY_FLAG && f_n == FIXED_REG
      |=> fixed_data_register_o == {31'h0, $past(test_flag_i)})
      else $error("flag copy wrong");
   long_mul_time_a: assert property (@(posedge core_clk_i) disable iff (!rst_n_i)
      take_w && instr_i[15:12] == GRP_ZERO && f_d == LO_LONG_MUL
      |=> !instr_ready_o ##1 !instr_ready_o ##1 instr_ready_o)
      else $error("long multiply timing wrong");
   // word multiplies take two states, inside the allowed range
   word_mul_time_a: assert property (@(posedge core_clk_i) disable iff (!rst_n_i)
      take_w && instr_i[15:12] == GRP_TWO && (f_d == LO_SMUL || f_d == LO_UMUL)
      |=> !instr_ready_o ##1 instr_ready_o)
      else $error("word multiply timing wrong");
   multiply_accum_high_hold_a: assert property (@(posedge core_clk_i) disable iff (!rst_n_i)
      $stable(multiply_accum_high_o))
      else $error("high mac changed");
   pc_step_a: assert property (@(posedge core_clk_i) disable iff (!rst_n_i)
      take_w && !delay_slot_i |=> pc_o == $past(pc_o) + INSTR_BYTES)
      else $error("pc did not advance by two");
endmodule : disp_move_and_multiply_exec

// ==== rtl/disp_exec_pkg.sv ====
// constants for the displacement move / multiply execution block
// assumes a 16-bit instruction stream and 32-bit data bus of one beat per access
package disp_exec_pkg;
   localparam logic [7:0] OP_BYTE_STORE = 8'h80;
   localparam logic [7:0] OP_WORD_STORE = 8'h81;
   localparam logic [7:0] OP_BYTE_LOAD = 8'h84;
   localparam logic [7:0] OP_WORD_LOAD = 8'h85;
   localparam logic [7:0] OP_EFF_ADDR = 8'hC7;
   localparam logic [3:0] OP_LONG_STORE = 4'h1;
   localparam logic [3:0] OP_LONG_LOAD = 4'h5;
   localparam logic [3:0] GRP_ZERO = 4'h0;
   localparam logic [3:0] GRP_TWO = 4'h2;
   localparam logic [7:0] LO_COPY_FLAG = 8'h29;
   localparam logic [3:0] LO_LONG_MUL = 4'h7;
   localparam logic [3:0] LO_SMUL = 4'hF;
   localparam logic [3:0] LO_UMUL = 4'hE;
   localparam logic [31:0] INSTR_BYTES = 32'h0000_0002;
   localparam logic [31:0] SLOT_PC_ADD = 32'h0000_0002;
   localparam logic [31:0] PC_ALIGN_MASK = 32'hFFFF_FFFC;
   localparam logic [31:0] PC_RESET = 32'h0000_0000;
   localparam logic [2:0] LONG_MUL_CYCLES = 3'h2;
   localparam logic [2:0] WORD_MUL_CYCLES = 3'h1;
   localparam logic [3:0] FIXED_REG = 4'h0;
   localparam logic [1:0] SIZE_BYTE = 2'h0;
   localparam logic [1:0] SIZE_WORD = 2'h1;
   localparam logic [1:0] SIZE_LONG = 2'h2;
endpackage : disp_exec_pkg

// ==== dv/mem_model.sv ====
// data memory partner: answers every request with one done pulse after lat_i idle cycles
// assumes requests are one-cycle pulses and never overlap an access in flight
`timescale 1ns/1ps
module mem_model (
   input wire logic core_clk_i,
   input wire logic rst_n_i,
   input wire logic mem_req_i,
   input wire logic [31:0] addr_i,
   input wire logic [3:0] lat_i,
   output logic done_o,
   output logic [31:0] rdata_o
);
   logic pend_r;
   logic [3:0] cnt_r;
   logic [31:0] addr_r;
   logic [31:0] junk_r;
   always_ff @(posedge core_clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         pend_r <= 1'b0;
         cnt_r <= 4'h0;
         addr_r <= 32'h0;
         junk_r <= 32'h5A5A_A5A5;
         done_o <= 1'b0;
         rdata_o <= 32'h0;
      end else begin
         done_o <= 1'b0;
         // data is only valid with done; a changing pattern exposes late sampling
         junk_r <= junk_r + 32'h9E37_79B9;
         rdata_o <= junk_r;
         if (mem_req_i) begin
            pend_r <= 1'b1;
            cnt_r <= lat_i;
            addr_r <= addr_i;
         end else if (pend_r && cnt_r == 4'h0) begin
            pend_r <= 1'b0;
            done_o <= 1'b1;
            rdata_o <= ~addr_r;
         end else if (pend_r) begin
            cnt_r <= cnt_r - 4'h1;
         end
      end
   end
endmodule : mem_model

// ==== dv/disp_move_and_multiply_exec_tb.sv ====
// self-checking bench for the displacement move / multiply execution block
// assumes the memory model returns the inverted address as load data
`timescale 1ns/1ps
module disp_move_and_multiply_exec_tb;
   import disp_exec_pkg::*;
   logic clk = 1'b0, rst_n = 1'b0, valid = 1'b0, slot = 1'b0, flag = 1'b0;
   logic [15:0] ins = 16'h0;
   logic [31:0] bdest = 32'h0, rdata, addr, wdata, multiply_accum_low, multiply_accum_high, fdr, pc;
   logic done, ready, req, we, busy;
   logic [1:0] size;
   logic [3:0] lat = 4'h0;
   logic [31:0] rf [16];
   logic [31:0] exp_pc = PC_RESET;
   int err_total = 0, n_tests = 0;
   always #20 clk = ~clk;
   disp_move_and_multiply_exec dut (.core_clk_i(clk), .rst_n_i(rst_n), .instr_valid_i(valid),
      .instr_i(ins), .delay_slot_i(slot), .branch_dest_i(bdest), .test_flag_i(flag),
      .mem_rdata_i(rdata), .mem_done_i(done), .instr_ready_o(ready), .pc_o(pc),
      .mem_req_o(req), .mem_we_o(we), .mem_size_o(size), .mem_addr_o(addr),
      .mem_wdata_o(wdata), .multiply_accum_low_o(multiply_accum_low), .multiply_accum_high_o(multiply_accum_high),
      .fixed_data_register_o(fdr), .busy_o(busy));
   mem_model mem (.core_clk_i(clk), .rst_n_i(rst_n), .mem_req_i(req), .addr_i(addr),
      .lat_i(lat), .done_o(done), .rdata_o(rdata));
   task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
      n_tests++;
      if (seen !== exp) begin
         err_total++;
         $display("BAD %s expected %h seen %h", nm, exp, seen);
      end
   endtask : chk
   task automatic conclude();
      $display("comparisons %0d mismatches %0d", n_tests, err_total);
      if (err_total == 0 && n_tests > 0) $display("RESULT: PASS");
      else $display("RESULT: FAIL");
      $finish;
   endtask : conclude
   // hold the request until taken, then wait for ready and idle again
   task automatic issue(input logic [15:0] i, input logic s, input logic [31:0] b, output int c);
      int k;
      chk("pc", pc, exp_pc);
      @(posedge clk);
      ins <= i;
      slot <= s;
      bdest <= b;
      valid <= 1'b1;
      k = 0;
      do begin
         @(negedge clk);
         k++;
      end while (ready !== 1'b1 && k < 60);
      @(posedge clk);
      valid <= 1'b0;
      slot <= 1'b0;
      c = 0;
      do begin
         @(negedge clk);
         c++;
      end while (!(ready === 1'b1 && busy === 1'b0) && c < 60);
      chk("handshake limit", {31'h0, k >= 60 || c >= 60}, 32'h0);
      exp_pc = s ? b : exp_pc + INSTR_BYTES;
   endtask : issue
   task automatic t_ea(input logic [7:0] d, input logic s, input logic [31:0] b);
      int c;
      rf[0] = ((s ? b + SLOT_PC_ADD : exp_pc + 32'h4) & PC_ALIGN_MASK) + {22'h0, d, 2'h0};
      issue({OP_EFF_ADDR, d}, s, b, c);
      chk("ea", fdr, rf[0]);
      chk("ea states", c, 1);
      $display("done t_ea");
   endtask : t_ea
   task automatic t_mem(input logic ld, input logic [1:0] sz, input logic [3:0] b, r, d);
      logic [31:0] a, v, mk;
      logic [15:0] i;
      int c;
      i = sz == SIZE_LONG ? (ld ? {OP_LONG_LOAD, r, b, d} : {OP_LONG_STORE, b, r, d})
                          : {4'h8, 1'b0, ld, 1'b0, sz[0], b, d};
      a = rf[b] + ({28'h0, d} << sz);
      mk = sz == SIZE_BYTE ? 32'hFF : (sz == SIZE_WORD ? 32'hFFFF : 32'hFFFF_FFFF);
      v = ld ? ~a : rf[sz == SIZE_LONG ? r : FIXED_REG];
      issue(i, 1'b0, 32'h0, c);
      chk("addr", addr, a);
      chk("size", {30'h0, size}, {30'h0, sz});
      chk("we", {31'h0, we}, {31'h0, ~ld});
      if (ld) begin
         if (sz == SIZE_BYTE) v = {{24{v[7]}}, v[7:0]};
         if (sz == SIZE_WORD) v = {{16{v[15]}}, v[15:0]};
         rf[sz == SIZE_LONG ? r : FIXED_REG] = v;
         chk("r0", fdr, rf[0]);
      end else begin
         chk("wdata", wdata & mk, v & mk);
      end
      $display("done t_mem");
   endtask : t_mem
   task automatic t_mul(input logic [3:0] lo, input logic [3:0] n, m);
      logic signed [15:0] sa, sb;
      logic signed [31:0] sp;
      logic [31:0] e;
      int c;
      sa = rf[n][15:0];
      sb = rf[m][15:0];
      sp = sa * sb;
      e = lo == LO_LONG_MUL ? rf[n] * rf[m] : (lo == LO_SMUL ? sp : rf[n][15:0] * rf[m][15:0]);
      issue({lo == LO_LONG_MUL ? GRP_ZERO : GRP_TWO, n, m, lo}, 1'b0, 32'h0, c);
      chk("multiply_accum_low", multiply_accum_low, e);
      chk("multiply_accum_high", multiply_accum_high, 32'h0);
      chk("mul states", c, lo == LO_LONG_MUL ? 3 : 2);
      $display("done t_mul");
   endtask : t_mul
   task automatic t_flag(input logic f);
      int c;
      @(posedge clk);
      flag <= f;
      @(negedge clk);
      issue({GRP_ZERO, FIXED_REG, LO_COPY_FLAG}, 1'b0, 32'h0, c);
      rf[0] = {31'h0, f};
      chk("flag copy", fdr, rf[0]);
      issue(16'h0009, 1'b0, 32'h0, c);
      chk("nop keeps r0", fdr, rf[0]);
      $display("done t_flag");
   endtask : t_flag
   initial begin
      #(40 * 4000);
      err_total++;
      conclude();
   end
   initial begin
      for (int j = 0; j < 16; j++) rf[j] = 32'h0;
      repeat (3) @(posedge clk);
      rst_n <= 1'b1;
      @(negedge clk);
      t_ea(8'hFF, 1'b0, 32'h0);
      t_ea(8'h01, 1'b1, 32'h0000_1236);
      t_mem(1'b1, SIZE_BYTE, 4'h0, 4'h0, 4'hF);
      lat = 4'h3;
      t_mem(1'b1, SIZE_WORD, 4'h0, 4'h0, 4'h1);
      t_mem(1'b1, SIZE_LONG, 4'h0, 4'h1, 4'hF);
      t_mem(1'b1, SIZE_LONG, 4'h0, 4'h2, 4'h2);
      t_mem(1'b0, SIZE_LONG, 4'h2, 4'h1, 4'h3);
      t_mem(1'b0, SIZE_BYTE, 4'h1, 4'h0, 4'h5);
      t_mem(1'b0, SIZE_WORD, 4'h2, 4'h0, 4'hF);
      t_mul(LO_SMUL, 4'h1, 4'h2);
      t_mul(LO_UMUL, 4'h1, 4'h2);
      t_mul(LO_LONG_MUL, 4'h1, 4'h2);
      t_flag(1'b1);
      t_flag(1'b0);
      chk("pc", pc, exp_pc);
      conclude();
   end
endmodule : disp_move_and_multiply_exec_tb
